/* design/fractional_pll_controller.sv */
// control, gating and status logic around the fractional loop core
module fractional_pll_controller
  import pll_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic               ref_clk,
  input  wire logic               nrst,
  // software control
  input  wire logic               enable,
  input  wire logic [1:0]         reference_select,
  input  wire logic [DIV_W-1:0]   xtal_divider,
  input  wire logic               ratio_wr,
  input  wire logic [RINT_W-1:0]  ratio_integer,
  input  wire logic [RFRAC_W-1:0] ratio_fraction,
  input  wire logic [2:0]         lock_time_sel,
  input  wire logic               wake_fast,
  input  wire logic               lock_bypass,
  input  wire logic               filter_override,
  input  wire logic [1:0]         filter_value,
  input  wire logic               low_power_en,
  input  wire logic [3:0]         flag_clear,
  // loop core and clock inputs from other domains
  input  wire logic               core_lock,
  input  wire logic               core_startup_done,
  input  wire logic               lock_timer_clock,
  // loop core control
  output logic                    core_enable_r,
  output logic [1:0]              ref_mux_sel_r,
  output logic [11:0]             ref_divisor_r,
  output logic [MULT_W-1:0]       loop_mult_q4_r,
  output logic                    frac_mode_r,
  output logic                    filter_auto_r,
  output logic [1:0]              filter_sel_r,
  output logic                    tdc_bypass_r,
  // output clock gate and status
  output logic                    output_clock_gate_r,
  output logic                    lock_status_r,
  output logic                    clock_stable_r,
  output logic [3:0]              interrupt_flag_r
);

  // synchronised foreign inputs
  logic lock_s, ready_s, ltclk_s, ltclk_d_r;
  sync2 #(.W(3)) u_sync (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .d       ({core_lock, core_startup_done, lock_timer_clock}),
    .q       ({lock_s, ready_s, ltclk_s})
  );

  // lock timer on the 32 kHz tick
  lock_timer_if tif ();
  lock_timer u_timer (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .tif     (tif)
  );

  pll_state_t           state_r, state_nxt;
  logic                 en_d_r, timer_ok_r, timer_ok_nxt;
  logic [SETTLE_W-1:0]  settle_r, settle_nxt;
  logic                 lock_ind, start_evt, ratio_evt, lt_on;
  logic                 gate_nxt, lock_nxt, stable_nxt;
  logic [3:0]           flags_nxt;
  logic [RINT_W-1:0]    rint_r, rint_nxt;
  logic [RFRAC_W-1:0]   rfrac_r, rfrac_nxt;

  // event decode
  assign start_evt = enable && !en_d_r;
  assign ratio_evt = ratio_wr && enable;
  assign lt_on     = (lock_time_sel != 3'h0);
  assign tif.tick  = ltclk_s && !ltclk_d_r;
  assign tif.start = (start_evt || ratio_evt) && lt_on;
  assign tif.load  = lt_ticks(lock_time_sel);

  // lock source: timer validated or core lock, masked while settling
  always_comb begin
    if (lt_on) begin
      lock_ind = timer_ok_r;
    end else begin
      lock_ind = lock_s;
    end
    if (settle_r != '0) begin
      lock_ind = 1'b0;
    end
    // a ratio write drops lock on its own edge, before the mask is loaded
    if (ratio_evt) begin
      lock_ind = 1'b0;
    end
  end

  // sequencer, lock timer validation and settle counter
  always_comb begin
    state_nxt    = state_r;
    timer_ok_nxt = timer_ok_r;
    settle_nxt   = settle_r;
    if (tif.done) begin
      timer_ok_nxt = 1'b1;
    end
    if (tif.start) begin
      timer_ok_nxt = 1'b0;
    end
    if (ratio_evt) begin
      settle_nxt = SETTLE_W'(SETTLE_CYC);
    end else if (settle_r != '0) begin
      settle_nxt = settle_r - 1'b1;
    end
    case (state_r)
      ST_OFF: begin
        if (enable) begin
          state_nxt = ST_STARTUP;
        end
      end
      ST_STARTUP: begin
        if (ready_s) begin
          state_nxt = wake_fast ? ST_RUN : ST_ACQ;
        end
      end
      ST_ACQ: begin
        if (lt_on ? tif.done : lock_ind) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: state_nxt = ST_RUN;
      default: state_nxt = ST_OFF;
    endcase
    if (!enable) begin
      state_nxt    = ST_OFF;
      timer_ok_nxt = 1'b0;
      settle_nxt   = '0;
    end
  end

  // gate, lock and stability
  always_comb begin
    gate_nxt   = (state_nxt == ST_RUN) && (lock_bypass || lock_ind);
    if (state_r != ST_RUN && state_nxt == ST_RUN) begin
      gate_nxt = 1'b1;
    end
    lock_nxt   = enable && lock_ind;
    stable_nxt = enable && lock_nxt;
  end

  // interrupt flags: set wins over write-one clear
  always_comb begin
    flags_nxt = interrupt_flag_r & ~flag_clear;
    if (lock_nxt && !lock_status_r) begin
      flags_nxt[FLG_LOCK] = 1'b1;
    end
    if (!lock_nxt && lock_status_r && enable) begin
      flags_nxt[FLG_FAIL] = 1'b1;
      if (state_r == ST_RUN) begin
        flags_nxt[FLG_LOST] = 1'b1;
      end
    end
    if (tif.done && enable) begin
      flags_nxt[FLG_LOCK_TIMER_TIMEOUT_FLAG] = 1'b1;
    end
  end

  // ratio holding registers
  always_comb begin
    rint_nxt  = rint_r;
    rfrac_nxt = rfrac_r;
    if (ratio_wr) begin
      rint_nxt  = ratio_integer;
      rfrac_nxt = ratio_fraction;
    end
  end

  // sequencer registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_r             <= ST_OFF;
      en_d_r              <= 1'b0;
      ltclk_d_r           <= 1'b0;
      timer_ok_r          <= 1'b0;
      settle_r            <= '0;
      output_clock_gate_r <= 1'b0;
      lock_status_r       <= 1'b0;
      clock_stable_r      <= 1'b0;
      interrupt_flag_r    <= FLAGS_RST;
    end else begin
      state_r             <= state_nxt;
      en_d_r              <= enable;
      ltclk_d_r           <= ltclk_s;
      timer_ok_r          <= timer_ok_nxt;
      settle_r            <= settle_nxt;
      output_clock_gate_r <= gate_nxt;
      lock_status_r       <= lock_nxt;
      clock_stable_r      <= stable_nxt;
      interrupt_flag_r    <= flags_nxt;
    end
  end

  // core configuration registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rint_r         <= '0;
      rfrac_r        <= '0;
      core_enable_r  <= 1'b0;
      ref_mux_sel_r  <= REF_SLOW_XTAL;
      ref_divisor_r  <= DIVISOR_RST;
      loop_mult_q4_r <= MULT_RST;
      frac_mode_r    <= 1'b0;
      filter_auto_r  <= 1'b1;
      filter_sel_r   <= 2'h0;
      tdc_bypass_r   <= 1'b0;
    end else begin
      rint_r         <= rint_nxt;
      rfrac_r        <= rfrac_nxt;
      core_enable_r  <= enable;
      ref_mux_sel_r  <= (reference_select > REF_GENERIC) ? REF_SLOW_XTAL
                        : reference_select;
      ref_divisor_r  <= {xtal_divider, 1'b0} + 12'h0_002;
      loop_mult_q4_r <= ({5'h00, rint_nxt} + 17'h0_0001) * 17'(FRAC_DEN)
                        + {13'h0000, rfrac_nxt};
      frac_mode_r    <= (rfrac_nxt != '0);
      filter_auto_r  <= !filter_override;
      filter_sel_r   <= filter_value;
      tdc_bypass_r   <= low_power_en;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  a_gate_off_dis: assert property (!enable |=> !output_clock_gate_r)
    else $error("gate open while disabled");
  a_stable_lock: assert property (clock_stable_r |-> lock_status_r && $past(enable))
    else $error("stable without lock and enable");
  a_ratio_unlock: assert property (ratio_wr && enable |=> !lock_status_r [*8])
    else $error("lock kept after ratio write");
  a_fail_flag: assert property ($fell(lock_status_r) && $past(enable)
                                |-> interrupt_flag_r[FLG_FAIL])
    else $error("lock fall not flagged");
  a_flag_hold: assert property (interrupt_flag_r[FLG_FAIL] && !flag_clear[FLG_FAIL]
                                |=> interrupt_flag_r[FLG_FAIL])
    else $error("fail flag lost without clear");
  a_frac_mode: assert property (ratio_wr |=> frac_mode_r == ($past(ratio_fraction) != 4'h0))
    else $error("fraction mode wrong");
  a_mult_val: assert property (ratio_wr |=> loop_mult_q4_r ==
                               17'(({5'h00, $past(ratio_integer)} + 17'h1) * 17'h10
                               + $past(ratio_fraction)))
    else $error("multiply ratio wrong");
  a_div_val: assert property (ref_divisor_r == 12'(({1'b0, $past(xtal_divider)} << 1) + 2))
    else $error("divisor wrong");
  a_tdc_bypass: assert property (low_power_en |=> tdc_bypass_r)
    else $error("time-to-digital bypass missed");
  a_lock_timer_timeout_flag_flag: assert property (tif.done && enable |=> interrupt_flag_r[FLG_LOCK_TIMER_TIMEOUT_FLAG])
    else $error("timeout not flagged");
  a_wake_fast: assert property (state_r == ST_STARTUP && ready_s && wake_fast && enable
                                |=> output_clock_gate_r)
    else $error("wake fast gate not opened");
  a_bypass_run: assert property (state_r == ST_RUN && lock_bypass && enable
                                 |=> output_clock_gate_r)
    else $error("bypass gate closed");

  // first edge and gating checks
  a_gate_closed: assert property (state_r != ST_RUN |-> !output_clock_gate_r)
    else $error("gate open outside run");
  a_normal_edge: assert property (
    state_r == ST_ACQ && enable && !lt_on && lock_ind |=> output_clock_gate_r)
    else $error("first edge missed at lock");
  a_timer_edge: assert property (
    state_r == ST_ACQ && enable && lt_on && tif.done |=> output_clock_gate_r)
    else $error("first edge missed at timeout");
  a_timer_wait: assert property (
    state_r == ST_ACQ && lt_on && !tif.done |=> !output_clock_gate_r)
    else $error("gate opened before timeout");
  a_gate_lock: assert property (
    state_r == ST_RUN && enable && !lock_bypass && !lock_ind |=> !output_clock_gate_r)
    else $error("gate open without lock");
  a_off_state: assert property (!enable |=> state_r == ST_OFF)
    else $error("sequencer running while disabled");

  // lock flag and mask checks
  a_lock_flag: assert property ($rose(lock_status_r) |-> interrupt_flag_r[FLG_LOCK])
    else $error("lock rise not flagged");
  a_lost_flag: assert property (
    $fell(lock_status_r) && $past(enable) && $past(state_r) == ST_RUN |-> interrupt_flag_r[FLG_LOST])
    else $error("lock loss in run not flagged");
  a_settle_mask: assert property (settle_r != '0 |=> !lock_status_r)
    else $error("lock shown while settling");

  // configuration and timer checks
  a_core_en: assert property (core_enable_r == $past(enable))
    else $error("core enable does not follow enable");
  a_ref_sel: assert property (ref_mux_sel_r != 2'h3)
    else $error("reference select outside three sources");
  a_filter_auto: assert property (filter_auto_r == !$past(filter_override))
    else $error("filter automatic flag wrong");
  a_timer_busy: assert property (tif.start |=> tif.busy)
    else $error("lock timer not loaded at start");

  // cover points

  c_normal_lock: cover property (state_r == ST_ACQ && !lt_on ##1 state_r == ST_RUN);
  c_timer_lock: cover property (tif.done && state_r == ST_ACQ);
  c_wake_fast: cover property (state_r == ST_STARTUP && wake_fast ##1 state_r == ST_RUN);
  c_ratio_relock: cover property (ratio_evt ##[1:200] $rose(lock_status_r));
  c_bypass_run: cover property (state_r == ST_RUN && lock_bypass && !lock_ind);
endmodule // fractional_pll_controller

/* design/lock_timer.sv */
// lock timer counting 32 kHz ticks down to zero
module lock_timer (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic nrst,
  // control
  lock_timer_if.timer tif
);
  logic [15:0] cnt_r, cnt_nxt;
  logic        done_r, done_nxt;

  // load on start, decrement per tick, pulse on reaching zero
  always_comb begin
    cnt_nxt  = cnt_r;
    done_nxt = 1'b0;
    if (tif.start) begin
      cnt_nxt = tif.load;
    end else if (tif.tick && cnt_r != 16'h0000) begin
      cnt_nxt  = cnt_r - 16'h0001;
      done_nxt = (cnt_r == 16'h0001);
    end
  end

  // registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r  <= 16'h0000;
      done_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign tif.done = done_r;
  assign tif.busy = (cnt_r != 16'h0000);
endmodule // lock_timer

/* design/sync2.sv */
// two-flop synchroniser for levels from foreign clocks
module sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // sync2

/* shared/lock_timer_if.sv */
// handshake between controller and its lock timer
interface lock_timer_if;
  logic            start;
  logic            tick;
  logic [15:0]     load;
  logic            done;
  logic            busy;

  modport ctrl (output start, output tick, output load, input done, input busy);
  modport timer (input start, input tick, input load, output done, output busy);
endinterface

/* shared/pll_ctrl_pkg.sv */
// shared constants, types and timing figures for the fractional loop controller
package pll_ctrl_pkg;

  // reference select encodings
  localparam logic [1:0] REF_SLOW_XTAL = 2'h0;
  localparam logic [1:0] REF_MULTI_XTAL = 2'h1;
  localparam logic [1:0] REF_GENERIC = 2'h2;

  // field widths
  localparam int DIV_W = 11;
  localparam int RINT_W = 12;
  localparam int RFRAC_W = 4;
  localparam int LT_W = 16;
  localparam int MULT_W = 17;

  // ratio fraction denominator and its shift
  localparam int FRAC_DEN = 16;
  localparam int FRAC_SH = 4;

  // flag vector bit positions
  localparam int FLG_LOCK = 0;
  localparam int FLG_LOST = 1;
  localparam int FLG_FAIL = 2;
  localparam int FLG_LOCK_TIMER_TIMEOUT_FLAG = 3;

  // reset values
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [MULT_W-1:0] MULT_RST = 17'h0_0010;
  localparam logic [11:0] DIVISOR_RST = 12'h0_002;

  // lock timer base interval, in 32 kHz ticks, doubled per select step
  localparam logic [LT_W-1:0] LT_BASE_TICKS = 16'h0_100;

  // time the lock stays masked after a ratio update
  localparam int CLK_PERIOD_NS = 40;
  localparam int SETTLE_NS = 2000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_W = 6;

  // controller states
  typedef enum logic [1:0] {ST_OFF, ST_STARTUP, ST_ACQ, ST_RUN} pll_state_t;

  // lock timer load value for a nonzero select
  function automatic logic [LT_W-1:0] lt_ticks(input logic [2:0] sel);
    lt_ticks = LT_BASE_TICKS << (sel - 3'h1);
  endfunction

endpackage

/* testbench/pll_core_model.sv */
// behavioural loop core and 32 kHz clock source facing the controller
module pll_core_model (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic nrst,
  // bench controls
  input  wire logic lock_hold,
  input  wire logic lock_drop,
  // controller side
  input  wire logic core_enable_r,
  output logic      core_startup_done,
  output logic      core_lock,
  output logic      lock_timer_clock
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt;

  // cycles since the controller enabled the core
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst || !core_enable_r) cnt <= 0;
    else if (cnt < 100) cnt <= cnt + 1;
  end

  // start-up after 10 cycles, lock 20 later; both drop at once on disable
  assign core_startup_done = core_enable_r && cnt >= 10;
  assign core_lock = core_startup_done && cnt >= 30 && !lock_hold && !lock_drop;

  // free 32 kHz stand-in, sped up and unrelated in phase to ref_clk
  initial lock_timer_clock = 1'b0;
  always #166.5 lock_timer_clock = ~lock_timer_clock;
endmodule // pll_core_model

/* testbench/test_fractional_pll_controller.sv */
// self-checking bench for the fractional loop controller
module test_fractional_pll_controller;
  import pll_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 0, nrst = 0, enable = 0, ratio_wr = 0, wake_fast = 0, lock_bypass = 0;
  logic filter_override = 0, low_power_en = 0, lock_hold = 0, lock_drop = 0;
  logic [1:0] reference_select = 2'h0, filter_value = 2'h0;
  logic [DIV_W-1:0] xtal_divider = '0;
  logic [RINT_W-1:0] ratio_integer = '0;
  logic [RFRAC_W-1:0] ratio_fraction = '0;
  logic [2:0] lock_time_sel = 3'h0;
  logic [3:0] flag_clear = 4'h0, interrupt_flag_r;
  logic core_lock, core_startup_done, lock_timer_clock, core_enable_r, frac_mode_r;
  logic filter_auto_r, tdc_bypass_r, output_clock_gate_r, lock_status_r, clock_stable_r;
  logic [1:0] ref_mux_sel_r, filter_sel_r;
  logic [11:0] ref_divisor_r;
  logic [MULT_W-1:0] loop_mult_q4_r;
  int errors = 0, checked = 0, cyc = 0, n, s;

  // clock and hang guard
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      close_out();
    end
  end

  fractional_pll_controller i_dut (.ref_clk(ref_clk), .nrst(nrst), .enable(enable),
    .reference_select(reference_select), .xtal_divider(xtal_divider), .ratio_wr(ratio_wr),
    .ratio_integer(ratio_integer), .ratio_fraction(ratio_fraction),
    .lock_time_sel(lock_time_sel), .wake_fast(wake_fast), .lock_bypass(lock_bypass),
    .filter_override(filter_override), .filter_value(filter_value),
    .low_power_en(low_power_en), .flag_clear(flag_clear), .core_lock(core_lock),
    .core_startup_done(core_startup_done), .lock_timer_clock(lock_timer_clock),
    .core_enable_r(core_enable_r), .ref_mux_sel_r(ref_mux_sel_r),
    .ref_divisor_r(ref_divisor_r), .loop_mult_q4_r(loop_mult_q4_r),
    .frac_mode_r(frac_mode_r), .filter_auto_r(filter_auto_r), .filter_sel_r(filter_sel_r),
    .tdc_bypass_r(tdc_bypass_r), .output_clock_gate_r(output_clock_gate_r),
    .lock_status_r(lock_status_r), .clock_stable_r(clock_stable_r),
    .interrupt_flag_r(interrupt_flag_r));

  pll_core_model i_core (.ref_clk(ref_clk), .nrst(nrst), .lock_hold(lock_hold),
    .lock_drop(lock_drop), .core_enable_r(core_enable_r),
    .core_startup_done(core_startup_done), .core_lock(core_lock),
    .lock_timer_clock(lock_timer_clock));

  // comparisons of multi-bit results and of single flags
  task automatic chk_val(input logic [MULT_W-1:0] got, input logic [MULT_W-1:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_val({16'h0, got}, {16'h0, exp});
  endtask

  // wait up to lim cycles for the gate (w=1) or lock status (w=0)
  task automatic wait_hi(input int w, input int lim);
    n = 0;
    while (!((w == 1) ? output_clock_gate_r === 1'b1 : lock_status_r === 1'b1) && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
  endtask
  task automatic cycles(input int k);
    repeat (k) @(negedge ref_clk);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    void'($urandom(98706));
    cycles(8);
    // reset values
    chk_val(ref_divisor_r, 17'h0_0002);
    chk_val(loop_mult_q4_r, MULT_RST);
    chk_bit(filter_auto_r, 1'b1);
    chk_val({interrupt_flag_r, output_clock_gate_r, lock_status_r, core_enable_r}, 17'h0);
    nrst = 1;
    $display("test reset done");
    // random configuration with the loop off; reference changes only while disabled
    for (int i = 0; i < 8; i++) begin
      xtal_divider = DIV_W'($urandom % 2047);
      ratio_integer = RINT_W'($urandom);
      ratio_fraction = (i == 0) ? 4'h0 : RFRAC_W'($urandom);
      reference_select = 2'(i);
      filter_override = 1'b1;
      filter_value = 2'($urandom);
      low_power_en = i[0];
      ratio_wr = 1;
      cycles(1);
      ratio_wr = 0;
      cycles(1);
      s = (i % 4 == 3) ? 0 : i % 4;
      chk_val(17'(ref_mux_sel_r), 17'(s));
      chk_val(17'(ref_divisor_r), 17'(2 * (int'(xtal_divider) + 1)));
      chk_val(loop_mult_q4_r, 17'((int'(ratio_integer) + 1) * 16 + int'(ratio_fraction)));
      chk_bit(frac_mode_r, ratio_fraction != 0);
      chk_val({filter_auto_r, filter_sel_r}, {1'b0, filter_value});
      chk_bit(tdc_bypass_r, i[0]);
    end
    filter_override = 0;
    cycles(2);
    chk_bit(filter_auto_r, 1'b1);
    $display("test config done");
    // normal start: gate closed until the core lock arrives
    enable = 1;
    cycles(20);
    chk_bit(output_clock_gate_r, 1'b0);
    wait_hi(1, 40);
    chk_val({output_clock_gate_r, lock_status_r, clock_stable_r}, 17'h7);
    chk_bit(interrupt_flag_r[FLG_LOCK], 1'b1);
    chk_bit(core_enable_r, 1'b1);
    $display("test normal start done");
    // ratio update on the fly drops lock for the settle time
    ratio_integer = 12'h5_DB;
    ratio_fraction = 4'h3;
    ratio_wr = 1;
    cycles(1);
    ratio_wr = 0;
    cycles(1);
    chk_bit(lock_status_r, 1'b0);
    chk_val(loop_mult_q4_r, 17'h0_5DC3);
    cycles(SETTLE_CYC - 8);
    chk_bit(lock_status_r, 1'b0);
    wait_hi(0, 20);
    chk_bit(lock_status_r, 1'b1);
    chk_val(17'(interrupt_flag_r[FLG_FAIL:FLG_LOST]), 17'h3);
    flag_clear = 4'hf;
    cycles(1);
    flag_clear = 4'h0;
    cycles(1);
    chk_val(17'(interrupt_flag_r), 17'h0);
    $display("test ratio update done");
    // lock loss gates the output unless bypassed
    for (int b = 0; b < 2; b++) begin
      lock_bypass = b[0];
      lock_drop = 1;
      cycles(8);
      chk_bit(output_clock_gate_r, b[0]);
      chk_bit(clock_stable_r, 1'b0);
      lock_drop = 0;
      wait_hi(0, 20);
      chk_bit(output_clock_gate_r, 1'b1);
    end
    lock_bypass = 0;
    $display("test bypass done");
    // disable holds the output off and keeps the flags
    enable = 0;
    cycles(2);
    chk_val({output_clock_gate_r, lock_status_r, clock_stable_r}, 17'h0);
    chk_bit(interrupt_flag_r[FLG_FAIL], 1'b1);
    flag_clear = 4'hf;
    cycles(1);
    flag_clear = 4'h0;
    $display("test disable done");
    // wake fast opens the gate at start-up end with no lock
    wake_fast = 1;
    lock_hold = 1;
    enable = 1;
    wait_hi(1, 30);
    chk_val({output_clock_gate_r, lock_status_r, clock_stable_r}, 17'h4);
    enable = 0;
    wake_fast = 0;
    lock_hold = 0;
    cycles(3);
    $display("test wake fast done");
    // timer mode: first edge only after 256 ticks
    lock_time_sel = 3'h1;
    enable = 1;
    cycles(1800);
    chk_bit(output_clock_gate_r, 1'b0);
    chk_bit(interrupt_flag_r[FLG_LOCK_TIMER_TIMEOUT_FLAG], 1'b0);
    wait_hi(1, 800);
    cycles(1); // timer-validated lock follows the first edge by one cycle
    chk_val({output_clock_gate_r, lock_status_r}, 17'h3);
    chk_bit(interrupt_flag_r[FLG_LOCK_TIMER_TIMEOUT_FLAG], 1'b1);
    $display("test lock timer done");
    close_out();
  end
endmodule // test_fractional_pll_controller
